// *** src/wdt_timer.v ***
// Purpose: watchdog timer with APB control, mode and sleep handling
// Assumes: 31 kHz oscillator arrives as a level input, sampled on MCLK
// Notes:   all outputs registered; CE low freezes every flip-flop
//          period and enable reach the counter at the next oscillator tick
//          unmapped offsets raise PSLVERR; status and count writes drop
//
// Summary of operation
// - time base only from 31 kHz oscillator
// - mode 11: always active, sleep included
// - mode 10: active awake, off in sleep
// - mode 01: software bit decides, sleep independent
// - software bit 1 runs, 0 stops
// - mode 00 off; bit ignored when top set
// - expiry while active and awake resets device
// - period code sets ratio 1:32 doubling
// - reserved codes act as 1:32
// - period code resets to 01011
// - many events clear the count
// - crystal wake holds clear until startup done
// - oscillator divider change leaves count alone
// - sleep entry clears, then resumes from zero
// - expiry in sleep wakes, updates flags
// - sleep entry clears power flag, sets expiry
// - control bits 7-6 zero, 5-1 period, 0 enable
`timescale 1ns/1ps
`include "wdt_map.vh"

module wdt_timer #(
    parameter CNT_W = `WDT_CNT_W
) (
    input  wire        MCLK,
    input  wire        RESETN,
    input  wire        CE,
    input  wire        PSEL,
    input  wire        PENABLE,
    input  wire        PWRITE,
    input  wire [7:0]  PADDR,
    input  wire [31:0] PWDATA,
    output wire [31:0] PRDATA,
    output wire        PREADY,
    output wire        PSLVERR,
    input  wire        LF_OSC_CLK,
    input  wire [1:0]  WATCHDOG_MODE_CFG,
    input  wire        WATCHDOG_CLEAR_OP,
    input  wire        SLEEP_ENTER,
    input  wire        SLEEP_WAKE,
    input  wire        OSC_FAIL,
    input  wire        STARTUP_TIMER_RUN,
    input  wire        CRYSTAL_CLOCK_MODE,
    output wire        WDT_RESET_REQ,
    output wire        WDT_WAKE_REQ,
    output wire        EXPIRY_FLAG_N,
    output wire        SLEEP_ENTERED_FLAG_N
);

    // ****************************************
    // functions
    // ****************************************
    // last count value of one period, in oscillator ticks
    function [CNT_W-1:0] period_last;
        input [4:0] ps;
        begin
            if (ps > `WDT_PS_MAX) begin
                period_last = `WDT_BASE_LAST;
            end else begin
                period_last = ((`WDT_BASE_LAST + 24'h000001) << ps)
                              - 24'h000001;
            end
        end
    endfunction

    // run decision for one mode; the enable bit only counts in mode 01
    function mode_active;
        input [1:0] mode;
        input       sleeping;
        input       swen;
        begin
            case (mode)
                `WDT_MODE_ON:    mode_active = 1'b1;
                `WDT_MODE_AWAKE: mode_active = ~sleeping;
                `WDT_MODE_SW:    mode_active = swen;
                default:         mode_active = 1'b0;
            endcase
        end
    endfunction

    // ****************************************
    // state
    // ****************************************
    reg             osc_s1_ff;
    reg             osc_s2_ff;
    reg             osc_s3_ff;
    reg [4:0]       period_select_ff;
    reg             sw_watchdog_enable_ff;
    reg             asleep_ff;
    reg             ost_hold_ff;
    reg             ost_run_d_ff;
    reg [CNT_W-1:0] count_ff;
    reg             reset_req_ff;
    reg             wake_req_ff;
    reg             expiry_n_ff;
    reg             sleep_n_ff;
    reg [31:0]      prdata_ff;
    reg             pready_ff;
    reg             pslverr_ff;
    reg [4:0]       ps_lf_ff;
    reg             swen_lf_ff;

    reg             active;
    reg             clear_cnt;
    wire            osc_tick;
    wire            expire;
    wire            apb_access;
    wire            apb_done;
    wire            hit_ctl;
    wire            hit_sta;
    wire            hit_cnt;
    wire            clr_state;
    wire            clr_event;
    wire            clr_osc;
    reg [31:0]      rd_value;

    // ****************************************
    // mode decode
    // ****************************************
    always @* begin
        active = mode_active(WATCHDOG_MODE_CFG, asleep_ff, swen_lf_ff);
    end

    // ****************************************
    // clearing conditions
    // ****************************************
    // the oscillator divider is not an input at all, so a divider change
    // cannot touch the count
    // divider independent
    assign clr_state = ~active;
    assign clr_event = WATCHDOG_CLEAR_OP | SLEEP_ENTER | SLEEP_WAKE;
    assign clr_osc   = OSC_FAIL | STARTUP_TIMER_RUN | ost_hold_ff;

    always @* begin
        clear_cnt = clr_state | clr_event | clr_osc;
    end

    // a crystal wake keeps the count at zero until the start-up timer
    // has run and stopped; the hold cannot end before it starts
    // hold until startup timer ends
    always @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            ost_hold_ff  <= 1'b0;
            ost_run_d_ff <= 1'b0;
        end else if (CE) begin
            ost_run_d_ff <= STARTUP_TIMER_RUN;
            if (SLEEP_WAKE && CRYSTAL_CLOCK_MODE) begin
                ost_hold_ff <= 1'b1;
            end else if (ost_run_d_ff && !STARTUP_TIMER_RUN) begin
                ost_hold_ff <= 1'b0;
            end
        end
    end

    // ****************************************
    // oscillator tick
    // ****************************************
    // the pin must stay at least four MCLK in each half period
    // first stage feeds only the second; edge taken from stages 2 and 3
    // oscillator synchroniser
    always @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            osc_s1_ff <= 1'b0;
            osc_s2_ff <= 1'b0;
            osc_s3_ff <= 1'b0;
        end else if (CE) begin
            osc_s1_ff <= LF_OSC_CLK;
            osc_s2_ff <= osc_s1_ff;
            osc_s3_ff <= osc_s2_ff;
        end
    end

    assign osc_tick = osc_s2_ff & ~osc_s3_ff;
    assign expire   = osc_tick & ~clear_cnt
                      & (count_ff == period_last(ps_lf_ff));

    // ****************************************
    // controls seen by the counter
    // ****************************************
    // new period and enable values land only on a tick, so a bus write
    // never splits the compare and the increment of one tick
    // controls into tick domain
    always @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            ps_lf_ff   <= `WDT_CTL_PS_RST;
            swen_lf_ff <= 1'b0;
        end else if (CE) begin
            if (osc_tick) begin
                ps_lf_ff   <= period_select_ff;
                swen_lf_ff <= sw_watchdog_enable_ff;
            end
        end
    end

    // ****************************************
    // counter and expiry
    // ****************************************
    // restarts at expiry, and wraps only if a shorter period lands below the count;
    // the longest code needs 23 of the CNT_W bits
    // tick counter
    always @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            count_ff <= {CNT_W{1'b0}};
        end else if (CE) begin
            if (clear_cnt || expire) begin
                count_ff <= {CNT_W{1'b0}};
            end else if (osc_tick) begin
                count_ff <= count_ff + {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    always @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            reset_req_ff <= 1'b0;
            wake_req_ff  <= 1'b0;
        end else if (CE) begin
            reset_req_ff <= expire & ~asleep_ff;
            wake_req_ff  <= expire & asleep_ff;
        end
    end

    // ****************************************
    // sleep state and status flags
    // ****************************************
    // a wake and an entry in one cycle leave the device awake
    // a same-cycle clear instruction blocks expiry, so the clear wins and no event is kept
    always @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            asleep_ff   <= 1'b0;
            expiry_n_ff <= 1'b1;
            sleep_n_ff  <= 1'b1;
        end else if (CE) begin
            if (SLEEP_WAKE) begin
                asleep_ff <= 1'b0;
            end else if (SLEEP_ENTER) begin
                asleep_ff <= 1'b1;
            end
            if (expire) begin
                expiry_n_ff <= 1'b0;
            end else if (SLEEP_ENTER) begin
                expiry_n_ff <= 1'b1;
                sleep_n_ff  <= 1'b0;
            end else if (WATCHDOG_CLEAR_OP) begin
                expiry_n_ff <= 1'b1;
                sleep_n_ff  <= 1'b1;
            end
        end
    end

    // ****************************************
    // APB slave
    // ****************************************
    // one wait state: read data captured in the first access cycle, write data in the second
    // writes to status and count are taken and dropped; only an
    // unmapped offset raises PSLVERR
    assign apb_access = PSEL & PENABLE & ~pready_ff;
    assign apb_done   = PSEL & PENABLE & pready_ff;
    assign hit_ctl    = (PADDR == `WDT_OFF_CONTROL);
    assign hit_sta    = (PADDR == `WDT_OFF_STATUS);
    assign hit_cnt    = (PADDR == `WDT_OFF_COUNT);

    // control, status and count read layout, upper bits zero
    always @* begin
        rd_value = 32'h00000000;
        if (hit_ctl) begin
            rd_value = {26'h0000000, period_select_ff,
                        sw_watchdog_enable_ff};
        end else if (hit_sta) begin
            rd_value = {28'h0000000, asleep_ff, active,
                        sleep_n_ff, expiry_n_ff};
        end else if (hit_cnt) begin
            rd_value = {{(32-CNT_W){1'b0}}, count_ff};
        end
    end

    always @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h00000000;
        end else if (CE) begin
            pready_ff <= apb_access;
            if (apb_access) begin
                pslverr_ff <= ~(hit_ctl | hit_sta | hit_cnt);
                prdata_ff  <= PWRITE ? 32'h00000000 : rd_value;
            end else begin
                pslverr_ff <= 1'b0;
            end
        end
    end

    always @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            period_select_ff      <= `WDT_CTL_PS_RST;
            sw_watchdog_enable_ff <= 1'b0;
        end else if (CE) begin
            if (apb_done && PWRITE && hit_ctl) begin
                period_select_ff <=
                    PWDATA[`WDT_CTL_PS_MSB:`WDT_CTL_PS_LSB];
                sw_watchdog_enable_ff <= PWDATA[`WDT_CTL_SWEN_BIT];
            end
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign PRDATA               = prdata_ff;
    assign PREADY               = pready_ff;
    assign PSLVERR              = pslverr_ff;
    assign WDT_RESET_REQ        = reset_req_ff;
    assign WDT_WAKE_REQ         = wake_req_ff;
    assign EXPIRY_FLAG_N        = expiry_n_ff;
    assign SLEEP_ENTERED_FLAG_N = sleep_n_ff;

endmodule

// *** common/wdt_map.vh ***
// Purpose: register map, field layout, reset values and timing constants
//          of the watchdog block
// Assumes: APB slave with 32-bit data, one register per aligned word
// Notes:   definitions only
`ifndef WDT_MAP_VH
`define WDT_MAP_VH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define WDT_ADDR_W          8
`define WDT_OFF_CONTROL     8'h00
`define WDT_OFF_STATUS      8'h04
`define WDT_OFF_COUNT       8'h08

// ****************************************
// control register fields
// ****************************************
`define WDT_CTL_SWEN_BIT    0
`define WDT_CTL_PS_LSB      1
`define WDT_CTL_PS_MSB      5
`define WDT_CTL_RST         6'h16
`define WDT_CTL_PS_RST      5'h0B

// ****************************************
// status register fields
// ****************************************
`define WDT_STA_EXPIRY_N    0
`define WDT_STA_SLEEP_N     1
`define WDT_STA_ACTIVE      2
`define WDT_STA_ASLEEP      3

// ****************************************
// watchdog modes and period codes
// ****************************************
`define WDT_MODE_OFF        2'h0
`define WDT_MODE_SW         2'h1
`define WDT_MODE_AWAKE      2'h2
`define WDT_MODE_ON         2'h3
`define WDT_PS_MAX          5'h12
`define WDT_CNT_W           24
`define WDT_BASE_LAST       24'h00001F

// ****************************************
// timing
// ****************************************
`define WDT_OSC_KHZ         31
`define WDT_BASE_MS         1

`endif

// *** dv/wdt_chk.sv ***
// Purpose: port-level assertions for wdt_timer
// Assumes: CE held high by the bench
// Notes:   attached by bind below
`timescale 1ns/1ps
module wdt_chk (
    input wire logic       MCLK,
    input wire logic       RESETN,
    input wire logic       PSEL,
    input wire logic       PENABLE,
    input wire logic [7:0] PADDR,
    input wire logic       PREADY,
    input wire logic       PSLVERR,
    input wire logic [1:0] WATCHDOG_MODE_CFG,
    input wire logic       WATCHDOG_CLEAR_OP,
    input wire logic       SLEEP_ENTER,
    input wire logic       WDT_RESET_REQ,
    input wire logic       WDT_WAKE_REQ,
    input wire logic       EXPIRY_FLAG_N,
    input wire logic       SLEEP_ENTERED_FLAG_N
);
    // ****
    // checks
    // ****
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RESETN);
    wire req = WDT_RESET_REQ || WDT_WAKE_REQ;
    a_req_exclusive: assert property (!(WDT_RESET_REQ && WDT_WAKE_REQ))
        else $error("reset and wake together");
    a_req_single: assert property (req |=> !req)
        else $error("request over one cycle");
    a_expiry_flag: assert property (req |-> !EXPIRY_FLAG_N)
        else $error("expiry flag missing");
    a_flag_cause: assert property ($fell(EXPIRY_FLAG_N) |-> req)
        else $error("expiry flag without request");
    a_off_quiet: assert property ((WATCHDOG_MODE_CFG == 2'h0) [*8] |-> !req)
        else $error("request while off");
    a_clear_holds: assert property (WATCHDOG_CLEAR_OP |-> ##6 !req [*8])
        else $error("request soon after clear");
    a_sleep_flags: assert property (SLEEP_ENTER ##1 !req |->
        !SLEEP_ENTERED_FLAG_N && EXPIRY_FLAG_N) else $error("sleep flags");
    a_apb_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
        else $error("ready late");
    a_slverr_map: assert property (PREADY |->
        PSLVERR == !(PADDR inside {8'h00, 8'h04, 8'h08})) else $error("slverr");
    c_reset: cover property (WDT_RESET_REQ);
    c_wake: cover property (WDT_WAKE_REQ);
    c_sleep: cover property (SLEEP_ENTER);
endmodule
bind wdt_timer wdt_chk i_chk (.*);

// *** dv/wdt_sys_model.sv ***
// Purpose: core and sleep controller beside the watchdog
// Assumes: oscillator half period of 5 MCLK keeps periods short
// Notes:   a watchdog wake request ends sleep, as the core would
`timescale 1ns/1ps
module wdt_sys_model (
    input  wire logic mclk,
    input  wire logic resetn,
    input  wire logic sleep_cmd,
    input  wire logic wake_cmd,
    input  wire logic wake_req,
    output logic      lf_osc,
    output logic      sleep_enter,
    output logic      sleep_wake
);
    logic [2:0] div_ff;
    logic       asleep_ff;
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            div_ff <= 3'h0;
            lf_osc <= 1'h0;
            asleep_ff <= 1'h0;
            sleep_enter <= 1'h0;
            sleep_wake <= 1'h0;
        end else begin
            div_ff <= (div_ff == 3'h4) ? 3'h0 : div_ff + 3'h1;
            lf_osc <= lf_osc ^ (div_ff == 3'h4);
            sleep_enter <= sleep_cmd && !asleep_ff;
            sleep_wake <= asleep_ff && (wake_cmd || wake_req);
            asleep_ff <= (asleep_ff || sleep_cmd) && !(wake_cmd || wake_req);
        end
    end
endmodule

// *** dv/tb_top.sv ***
// Purpose: self-checking bench for wdt_timer
// Assumes: CE tied high; one oscillator period is 10 MCLK
// Notes:   period windows allow for synchroniser and tick phase
`timescale 1ns/1ps
`include "wdt_map.vh"
module tb_top;
    logic        mclk, resetn = 1'h0, psel = 1'h0, penable = 1'h0;
    logic        pwrite = 1'h0, osc_fail = 1'h0, stt = 1'h0, xtal = 1'h0;
    logic        pready, pslverr, lf_osc, s_ent, s_wake, er;
    logic        rst_req, wake_req, exp_n, slp_n;
    logic [1:0]  mode = 2'h0;
    logic [2:0]  cmd = 3'h0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, d;
    int          mismatches, checks_done, i, ps, n_rst;
    int          pss [6] = '{0, 1, 2, 19, 31, 0};
    // mode, enable, asleep, expected request: 0 none, 1 reset, 2 wake
    int          tab [8][4] = '{'{3, 0, 0, 1}, '{3, 0, 1, 2}, '{2, 0, 1, 0},
        '{2, 0, 0, 1}, '{1, 1, 1, 2}, '{1, 0, 0, 0}, '{0, 1, 0, 0},
        '{1, 1, 0, 1}};
    wdt_sys_model i_sys (.mclk(mclk), .resetn(resetn), .sleep_cmd(cmd[1]),
        .wake_cmd(cmd[2]), .wake_req(wake_req), .lf_osc(lf_osc),
        .sleep_enter(s_ent), .sleep_wake(s_wake));
    wdt_timer i_dut (.MCLK(mclk), .RESETN(resetn), .CE(1'h1), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .LF_OSC_CLK(lf_osc), .WATCHDOG_MODE_CFG(mode),
        .WATCHDOG_CLEAR_OP(cmd[0]), .SLEEP_ENTER(s_ent), .SLEEP_WAKE(s_wake),
        .OSC_FAIL(osc_fail), .STARTUP_TIMER_RUN(stt),
        .CRYSTAL_CLOCK_MODE(xtal), .WDT_RESET_REQ(rst_req),
        .WDT_WAKE_REQ(wake_req), .EXPIRY_FLAG_N(exp_n),
        .SLEEP_ENTERED_FLAG_N(slp_n));
    // ****
    // helpers
    // ****
    initial begin
        mclk = 1'h0;
        forever #2.5 mclk = ~mclk;
    end
    always @(posedge mclk) if (rst_req === 1'h1) n_rst++;
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
        int n;
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge mclk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge mclk);
        if (n >= 20) begin
            mismatches++;
            final_report();
        end
    endtask
    // one-cycle command: 0 clear, 1 sleep, 2 wake
    task automatic pulse(input int b);
        cmd[b] <= 1'h1;
        @(posedge mclk);
        cmd <= 3'h0;
        repeat (2) @(posedge mclk);
    endtask
    function automatic int per(input int p);
        return (p > 18 ? 32 : 32 << p) * 10;
    endfunction
    task automatic watch(input int kind, input int p);
        int c;
        int got;
        got = 0;
        for (c = 0; c < per(p) + 40 && got == 0; c++) begin
            @(posedge mclk);
            got = (rst_req === 1'h1) ? 1 : (wake_req === 1'h1) ? 2 : 0;
        end
        chk(got, kind);
        if (kind != 0) chk(c > per(p) - 20 && c < per(p) + 20, 1);
    endtask
    // ****
    // sequence
    // ****
    initial begin
        void'($urandom(27));
        repeat (2) @(posedge mclk);
        resetn <= 1'h1;
        @(posedge mclk);
        apb(1'h0, `WDT_OFF_CONTROL, 32'h0);
        chk(rd, {26'h0, 5'h0B, 1'h0});
        apb(1'h0, `WDT_OFF_STATUS, 32'h0);
        chk(rd[3:0], 4'h3);
        apb(1'h0, 8'h0C, 32'h0);
        chk({31'h0, er}, 32'h1);
        for (i = 0; i < 4; i++) begin
            d = $urandom;
            apb(1'h1, `WDT_OFF_CONTROL, d);
            apb(1'h0, `WDT_OFF_CONTROL, 32'h0);
            chk(rd, {26'h0, d[5:0]});
        end
        $display("test registers done");
        mode <= 2'h3;
        pss[5] = $urandom_range(31, 19);
        for (i = 0; i < 6; i++) begin
            apb(1'h1, `WDT_OFF_CONTROL, pss[i] << 1);
            pulse(0);
            watch(1, pss[i]);
            chk(exp_n, 1'h0);
        end
        $display("test periods done");
        for (i = 0; i < 8; i++) begin
            mode <= tab[i][0][1:0];
            apb(1'h1, `WDT_OFF_CONTROL, tab[i][1]);
            pulse(0);
            if (tab[i][2] != 0) begin
                pulse(1);
                chk({slp_n, exp_n}, 2'h1);
            end
            watch(tab[i][3], 0);
            if (tab[i][3] == 2) chk({slp_n, exp_n}, 2'h0);
            pulse(2);
        end
        $display("test modes done");
        mode <= 2'h3;
        ps = n_rst;
        for (i = 0; i < 6; i++) begin
            repeat (250) @(posedge mclk);
            pulse(0);
        end
        chk(n_rst - ps, 0);
        osc_fail <= 1'h1;
        watch(0, 0);
        apb(1'h0, `WDT_OFF_COUNT, 32'h0);
        chk(rd, 32'h0);
        osc_fail <= 1'h0;
        stt <= 1'h1;
        watch(0, 0);
        stt <= 1'h0;
        xtal <= 1'h1;
        pulse(1);
        pulse(2);
        watch(0, 0);
        stt <= 1'h1;
        repeat (20) @(posedge mclk);
        stt <= 1'h0;
        watch(1, 0);
        $display("test clearing done");
        final_report();
    end
endmodule
